// ---- cmd_buf_pkg.sv ----
/*
 * Constants and carrier types for the configurable registered command buffer.
 * Assumes the configuration selects are static while the buffer runs.
 */
`default_nettype none

package cmd_buf_pkg;

    // ****************************************
    // Widths and channel positions
    // ****************************************
    localparam int NCH = 25;
    localparam int NCOL = 14;
    localparam int CH_PRIMARY_SELECT = 6;

    // ****************************************
    // Channel masks (bit n is channel n+1)
    // ****************************************
    localparam logic [NCH-1:0] CH_RESET = 25'h000_0000;
    localparam logic [NCH-1:0] CH_ALL = 25'h1FF_FFFF;
    localparam logic [NCH-1:0] CH_USED_FANOUT = 25'h000_3FFF;
    // Clock enable ch1, termination ch4, primary select ch7
    localparam logic [NCH-1:0] UNGATED_A = 25'h000_0049;
    // Clock enable ch14, termination ch11, primary select ch7
    localparam logic [NCH-1:0] UNGATED_B = 25'h000_2440;

    // ****************************************
    // Output column layout
    // ****************************************
    localparam logic [NCOL-1:0] COL_RESET = 14'h0000;
    // Second-column terminals left unused in one-to-one operation
    localparam logic [NCOL-1:0] UNUSED_TERMINAL = 14'h0049;

    typedef struct packed {
        logic fanout_mode_select;
        logic variant_select;
    } cfg_s;

endpackage

`default_nettype wire

// ---- cmd_buffer.sv ----
/*
 * Configurable registered buffer for memory-module address and command lines:
 * 25-bit one-to-one or 14-bit one-to-two (A or B arrangement), with chip-select
 * output freezing. Assumes inputs are synchronous to mclk and that the
 * configuration selects are strapped.
 */
// Contract
// - Capture active inputs each clock, drive outputs
// - Fanout high: 14-bit one-to-two, else 25-bit
// - Fanout: variant select low picks A, high B
// - One-to-one: three unused terminals held low
// - Under reset, floating inputs leave outputs unchanged
// - Reset clears registers, forces outputs low
// - Both selects high: gated outputs hold
// - Either select low: gated outputs update
// - Reset overrides chip-select gating
// - Channel roles: enable 1/14, termination 4/11, select 7
// - Enable, termination, select channels never frozen
// - Reset acts asynchronously
// - Unused inputs ignored, unused outputs low
`timescale 1ns/1ps
`default_nettype none

module cmd_buffer
(
    input wire logic mclk,                                          // Capture clock
    input wire logic reset,                                         // Asynchronous reset, active high
    input wire cmd_buf_pkg::cfg_s cfg,                              // Static arrangement selects
    input wire logic [cmd_buf_pkg::NCH-1:0] registered_inputs,      // Channels 1..25, ch7 slot unused
    input wire logic primary_select_in,                             // Primary chip select, channel 7
    input wire logic secondary_select_in,                           // Secondary chip select
    output logic [cmd_buf_pkg::NCOL-1:0] registered_outputs_a,      // First output column
    output logic [cmd_buf_pkg::NCOL-1:0] registered_outputs_b       // Second output column
);
    import cmd_buf_pkg::*;

    // ****************************************
    // Arrangement decode
    // ****************************************
    function automatic logic [NCH-1:0] ungated_mask(input cfg_s c);
        if (c.fanout_mode_select && c.variant_select)
        begin
            ungated_mask = UNGATED_B;
        end
        else
        begin
            ungated_mask = UNGATED_A;
        end
    endfunction

    // Packs channels 15..25 around the unused terminals of the second column
    function automatic logic [NCOL-1:0] second_column_1to1(input logic [NCH-1:0] ch);
        int k;
        k = NCOL;
        second_column_1to1 = COL_RESET;
        for (int p = 0; p < NCOL; p++)
        begin
            if (!UNUSED_TERMINAL[p])
            begin
                second_column_1to1[p] = ch[k];
                k = k + 1;
            end
        end
    endfunction

    logic [NCH-1:0] ch_q;
    logic [NCH-1:0] ch_d;
    logic [NCH-1:0] d_eff;
    logic [NCH-1:0] ungated;
    logic [NCOL-1:0] out_b_d;
    logic freeze;

    // ****************************************
    // Next channel values
    // ****************************************
    always_comb
    begin
        d_eff = registered_inputs;
        d_eff[CH_PRIMARY_SELECT] = primary_select_in;
        if (cfg.fanout_mode_select)
        begin
            d_eff = d_eff & CH_USED_FANOUT;
        end
        else
        begin
            d_eff = d_eff & CH_ALL;
        end
    end

    assign ungated = ungated_mask(cfg);
    assign freeze = primary_select_in & secondary_select_in;

    // Frozen channels reload their own value; ungated ones always load
    always_comb
    begin
        if (freeze)
        begin
            ch_d = (ch_q & ~ungated) | (d_eff & ungated);
        end
        else
        begin
            ch_d = d_eff;
        end
    end

    always_comb
    begin
        if (cfg.fanout_mode_select)
        begin
            out_b_d = ch_d[NCOL-1:0];
        end
        else
        begin
            out_b_d = second_column_1to1(ch_d);
        end
    end

    // ****************************************
    // Channel and output registers
    // ****************************************
    // Reset is asynchronous so outputs fall low even with no clock running,
    // which also makes floating inputs harmless during standby.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ch_q <= CH_RESET;
        end
        else
        begin
            ch_q <= ch_d;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            registered_outputs_a <= COL_RESET;
            registered_outputs_b <= COL_RESET;
        end
        else
        begin
            registered_outputs_a <= ch_d[NCOL-1:0];
            registered_outputs_b <= out_b_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_frozen_edge;
        !reset && freeze ##1 !reset;
    endsequence

    sequence s_open_edge;
        !reset && !freeze ##1 !reset;
    endsequence

    reset_low_a: assert property (@(posedge mclk)
        reset |-> (registered_outputs_a == COL_RESET && registered_outputs_b == COL_RESET && ch_q == CH_RESET))
        else $error("outputs not low under reset");

    gate_hold_a: assert property (@(posedge mclk) disable iff (reset)
        s_frozen_edge |-> ((ch_q & ~ungated) == ($past(ch_q) & ~ungated)))
        else $error("gated channel moved while both selects high");

    gate_open_a: assert property (@(posedge mclk) disable iff (reset)
        s_open_edge |-> (ch_q == $past(d_eff)))
        else $error("channel did not load with a select low");

    ungated_follow_a: assert property (@(posedge mclk) disable iff (reset)
        (!reset ##1 !reset) |-> ((ch_q & ungated) == ($past(d_eff) & ungated)))
        else $error("ungated channel failed to follow its input");

    select_channel_a: assert property (@(posedge mclk) disable iff (reset)
        (!reset ##1 !reset) |-> (ch_q[CH_PRIMARY_SELECT] == $past(primary_select_in)))
        else $error("primary select channel not registered");

    pair_equal_a: assert property (@(posedge mclk) disable iff (reset)
        cfg.fanout_mode_select |-> (registered_outputs_a == registered_outputs_b))
        else $error("A and B outputs differ");

    unused_low_a: assert property (@(posedge mclk) disable iff (reset)
        !cfg.fanout_mode_select |-> ((registered_outputs_b & UNUSED_TERMINAL) == COL_RESET))
        else $error("unused terminal driven high");

    unused_in_a: assert property (@(posedge mclk) disable iff (reset)
        cfg.fanout_mode_select |-> ((ch_q & ~CH_USED_FANOUT) == CH_RESET))
        else $error("unused input reached a channel");

    wide_map_a: assert property (@(posedge mclk) disable iff (reset)
        (!reset && !cfg.fanout_mode_select) ##1 !reset |->
            (registered_outputs_a == ch_q[NCOL-1:0] && registered_outputs_b == second_column_1to1(ch_q)))
        else $error("one-to-one column mapping wrong");

    variant_b_a: assert property (@(posedge mclk) disable iff (reset)
        (!reset && cfg.fanout_mode_select && cfg.variant_select && freeze) ##1 !reset |->
            (ch_q & UNGATED_B) == ($past(d_eff) & UNGATED_B))
        else $error("B arrangement froze a control channel");

    // ****************************************
    // Pin-level role checks
    // ****************************************
    // These read the output pins rather than ch_q, so a column wired to the
    // wrong channel shows up here even when the channel register is right.
    // Channel positions watched below (bit n is channel n+1)
    localparam int POS_ENABLE_NARROW = 0;
    localparam int POS_TERM_NARROW = 3;
    localparam int POS_TERM_B = 10;
    localparam int POS_ENABLE_B = 13;
    localparam int POS_SECOND_FIRST = 1;
    localparam int CH_SECOND_FIRST = 14;

    sequence s_run_edge;
        !reset ##1 !reset;
    endsequence

    sequence s_narrow_edge;
        (!reset && !(cfg.fanout_mode_select && cfg.variant_select)) ##1 !reset;
    endsequence

    sequence s_b_edge;
        (!reset && cfg.fanout_mode_select && cfg.variant_select) ##1 !reset;
    endsequence

    sequence s_wide_open_edge;
        (!reset && !cfg.fanout_mode_select && !freeze) ##1 !reset;
    endsequence

    run_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_run_edge |->
            (registered_outputs_a == ch_q[NCOL-1:0]))
        else $error("first column differs from channel register");

    fan_b_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_run_edge |->
            (!cfg.fanout_mode_select || registered_outputs_b == ch_q[NCOL-1:0]))
        else $error("second column differs from channel register");

    enable_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_narrow_edge |->
            (registered_outputs_a[POS_ENABLE_NARROW] == $past(registered_inputs[POS_ENABLE_NARROW])))
        else $error("clock enable pin not registered");

    term_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_narrow_edge |->
            (registered_outputs_a[POS_TERM_NARROW] == $past(registered_inputs[POS_TERM_NARROW])))
        else $error("termination pin not registered");

    b_term_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_b_edge |->
            (registered_outputs_a[POS_TERM_B] == $past(registered_inputs[POS_TERM_B])))
        else $error("B termination pin not registered");

    b_enable_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_b_edge |->
            (registered_outputs_a[POS_ENABLE_B] == $past(registered_inputs[POS_ENABLE_B])))
        else $error("B clock enable pin not registered");

    select_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_run_edge |->
            (registered_outputs_a[CH_PRIMARY_SELECT] == $past(primary_select_in)))
        else $error("primary select pin not registered");

    // Gating freezes the pins themselves, not only the channel register
    frozen_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_frozen_edge |->
            ((registered_outputs_a & ~ungated[NCOL-1:0]) == ($past(registered_outputs_a) & ~ungated[NCOL-1:0])))
        else $error("gated pin moved while both selects high");

    open_out_a: assert property (@(posedge mclk) disable iff (reset)
        s_open_edge |->
            (registered_outputs_a == $past(d_eff[NCOL-1:0])))
        else $error("pins did not load with a select low");

    release_low_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(reset) |->
            (registered_outputs_a == COL_RESET && registered_outputs_b == COL_RESET))
        else $error("outputs not low on reset release");

    wide_second_a: assert property (@(posedge mclk) disable iff (reset)
        s_wide_open_edge |->
            (registered_outputs_b[POS_SECOND_FIRST] == $past(registered_inputs[CH_SECOND_FIRST])))
        else $error("second column first channel misplaced");

    // Floating selects under reset read both high every other cycle
    reset_prio_a: assert property (@(posedge mclk)
        (reset && freeze) |->
            (registered_outputs_a == COL_RESET && registered_outputs_b == COL_RESET))
        else $error("gating overrode reset");

    b_gated_ch1_a: assert property (@(posedge mclk) disable iff (reset)
        (!reset && cfg.fanout_mode_select && cfg.variant_select && freeze) ##1 !reset |->
            (registered_outputs_a[POS_ENABLE_NARROW] == $past(registered_outputs_a[POS_ENABLE_NARROW])))
        else $error("B arrangement did not gate channel one");

endmodule

`default_nettype wire

// ---- mem_ctrl_model.sv ----
/*
 * Memory controller model that drives the command buffer inputs.
 * Assumes the bench calls its tasks just after a rising edge of mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model
(
    input wire logic mclk,                                  // Capture clock
    input wire logic reset,                                 // Buffer reset, seen to float the lines
    output var cmd_buf_pkg::cfg_s cfg,                      // Arrangement straps
    output logic [cmd_buf_pkg::NCH-1:0] registered_inputs,  // Channel data
    output logic primary_select_in,                         // Primary chip select
    output logic secondary_select_in                        // Secondary chip select
);
    import cmd_buf_pkg::*;

    logic [NCH+1:0] held_q;
    logic [NCH+1:0] noise_q;

    initial
    begin
        held_q = '0;
        noise_q = 27'h555_5557;
        cfg = '0;
    end

    // Floating lines under reset flip every cycle, selects both high every other cycle
    assign {registered_inputs, primary_select_in, secondary_select_in} = reset ? noise_q : held_q;

    always @(posedge mclk)
    begin
        noise_q <= ~noise_q;
    end

    // Straps change only while the buffer is held in reset
    task set_cfg(input cfg_s c);
        cfg <= c;
    endtask

    task drive(input logic [NCH-1:0] d, input logic ps, input logic ss);
        held_q <= {d, ps, ss};
    endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
/*
 * Self-checking bench for cmd_buffer in all three arrangements.
 * Assumes the package and the controller model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import cmd_buf_pkg::*;

    typedef struct packed {logic [NCH-1:0] data; logic ps; logic ss;} row_s;

    logic mclk;
    logic reset;
    cfg_s cfg;
    logic [NCH-1:0] registered_inputs;
    logic primary_select_in;
    logic secondary_select_in;
    logic [NCOL-1:0] registered_outputs_a;
    logic [NCOL-1:0] registered_outputs_b;
    logic [NCH-1:0] exp_ch;
    row_s pending;
    int err_count;
    int check_count;
    // ****************************************
    // Stimulus rows: data, primary, secondary
    // ****************************************
    row_s rows [8] = '{'{25'h1FF_FFFF, 1'h0, 1'h0}, '{25'h000_0000, 1'h1, 1'h1}, '{25'h155_5555, 1'h1, 1'h0},
        '{25'h0AA_AAAA, 1'h0, 1'h1}, '{25'h1FF_FFBF, 1'h1, 1'h1}, '{25'h000_0040, 1'h0, 1'h0},
        '{25'h123_4567, 1'h1, 1'h1}, '{25'h0FE_DCBA, 1'h0, 1'h0}};
    cfg_s modes [3] = '{2'h0, 2'h2, 2'h3};

    cmd_buffer u_cmd_buffer (.mclk(mclk), .reset(reset), .cfg(cfg), .registered_inputs(registered_inputs),
        .primary_select_in(primary_select_in), .secondary_select_in(secondary_select_in),
        .registered_outputs_a(registered_outputs_a), .registered_outputs_b(registered_outputs_b));
    mem_ctrl_model u_mem_ctrl_model (.mclk(mclk), .reset(reset), .cfg(cfg), .registered_inputs(registered_inputs),
        .primary_select_in(primary_select_in), .secondary_select_in(secondary_select_in));

    initial
    begin
        mclk = 1'b0;
    end

    always #5 mclk = ~mclk;

    task automatic chk(input string name, input logic [NCOL-1:0] seen, input logic [NCOL-1:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up;
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Drives one row back to back and checks the row captured at this same edge
    task automatic step(input row_s r);
        logic [NCH-1:0] d;
        logic [NCH-1:0] ug;
        logic [NCOL-1:0] eb;
        @(posedge mclk);
        u_mem_ctrl_model.drive(r.data, r.ps, r.ss);
        d = pending.data;
        d[CH_PRIMARY_SELECT] = pending.ps;
        ug = (cfg.fanout_mode_select && cfg.variant_select) ? UNGATED_B : UNGATED_A;
        exp_ch = (pending.ps && pending.ss) ? ((exp_ch & ~ug) | (d & ug)) : d;
        eb = cfg.fanout_mode_select ? exp_ch[NCOL-1:0]
            : {exp_ch[24:18], 1'b0, exp_ch[17:16], 1'b0, exp_ch[15:14], 1'b0};
        pending = r;
        #1;
        chk("out_a", registered_outputs_a, exp_ch[NCOL-1:0]);
        chk("out_b", registered_outputs_b, eb);
        #5;
        chk("out_a_held", registered_outputs_a, exp_ch[NCOL-1:0]);
    endtask

    // ****************************************
    // Main sequence: a reset session per arrangement
    // ****************************************
    initial
    begin
        err_count = 0;
        check_count = 0;
        reset = 1'b1;
        exp_ch = CH_RESET;
        pending = '0;
        foreach (modes[m])
        begin
            @(posedge mclk);
            reset <= 1'b1;
            u_mem_ctrl_model.set_cfg(modes[m]);
            #1;
            chk("async_clear", registered_outputs_a | registered_outputs_b, COL_RESET);
            repeat (11)
            begin
                @(posedge mclk);
                #1;
                chk("reset_out", registered_outputs_a | registered_outputs_b, COL_RESET);
            end
            @(posedge mclk);
            reset <= 1'b0;
            u_mem_ctrl_model.drive('0, 1'b0, 1'b0);
            exp_ch = CH_RESET;
            pending = '0;
            foreach (rows[i])
                step(rows[i]);
            step(rows[0]);
        end
        wrap_up();
    end

    // Watchdog against a hung run
    initial
    begin
        #20000;
        err_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
